// file: hdl/frame_tick_gen.sv
// operating clock enable: sub-clock or system clock divider
`timescale 1ns/1ns
`include "segment_lcd_params.svh"

module frame_tick_gen
(
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       run,
    input  wire logic [3:0] sel,
    input  wire logic       sub_tick,
    output logic            op_tick
);

    logic [`SYS_DIV_W-1:0] sys_cnt_r;
    logic [`SUB_DIV_W-1:0] sub_cnt_r;
    logic [`SYS_DIV_W-1:0] sys_mask;
    logic                  sub_hit;

    // halted counters restart from zero so the first tick after enable is a full period
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            sys_cnt_r <= '0;
        else if (!run)
            sys_cnt_r <= '0;
        else
            sys_cnt_r <= sys_cnt_r + 1'b1;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            sub_cnt_r <= '0;
        else if (!run)
            sub_cnt_r <= '0;
        else if (sub_tick)
            sub_cnt_r <= sub_cnt_r + 1'b1;
    end

    always_comb
    begin
        // divide by 2^(sel[2:0]+1): low bits of the counter all ones
        sys_mask = `SYS_DIV_W'((9'h002 << sel[2:0]) - 9'h001);
        if (sel[1])
            sub_hit = &sub_cnt_r;
        else if (sel[0])
            sub_hit = sub_cnt_r[0];
        else
            sub_hit = 1'b1;
    end

    assign op_tick = run & (sel[3] ? ((sys_cnt_r & sys_mask) == sys_mask)
                                   : (sub_tick & sub_hit));

endmodule : frame_tick_gen

// file: hdl/segment_lcd_control.sv
// segment lcd control: apb registers, pin roles, common timing and serial expansion
//
// Summary of operation
// - duty field bits 7:6 picks static, 1/2, 1/3 or 1/4 duty
// - common_parallel_sel repeats used backplane waveforms on the unused backplanes
// - expansion_pins_sel turns the top four front-plane pins into expansion signals
// - segment_pin_count maps 0, 8, 16, 24 or 32 top pins as drivers
// - expansion with count 0000: top four are expansion pins, 28 are ports
// - drive_power_on switches the lcd drive power
// - drive power forced off when controller off or chip in standby
// - controller_on low halts operation; registers keep their contents
// - show_ram_select low shows blank data, high shows display ram
// - software chooses the A or B drive waveform
// - frame_clk_sel sets the frame rate to suit the panel
// - expansion serial_seg_out carries display data serially
// - expansion polarity_flip_out carries the alternation signal
// - expansion latch_strobe_out carries the data latch clock
// - expansion shift_strobe_out carries the shift clock on the second-highest pin
// - frame_clk_sel picks sub-clock /1,/2,/4 or system clock /2 to /256
// - wave_type_sel bit 7: 0 selects A waveform, 1 selects B
// - boost_supply_sel bit 4: 0 plain supply, 1 runs the 5 V regulator
//
// The APB register port was left to the implementer.
`timescale 1ns/1ns
`include "segment_lcd_params.svh"

module segment_lcd_control
#(
    parameter int SEGS_PER_COM = 64
)
(
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [31:0]  paddr,
    input  wire logic [31:0]  pwdata,
    output logic      [31:0]  prdata,
    output logic              pready,
    output logic              pslverr,
    input  wire logic         sub_clk_tick,
    input  wire logic         standby,
    input  wire logic [255:0] ram_bits,
    output logic      [31:0]  frontplane_pin,
    output logic      [31:0]  frontplane_drv_en,
    output logic      [3:0]   backplane_out,
    output logic              drive_polarity,
    output logic              latch_strobe_out,
    output logic              shift_strobe_out,
    output logic              serial_seg_out,
    output logic              polarity_flip_out,
    output logic              expansion_active,
    output logic              lcd_power_on,
    output logic              boost_run,
    output logic              wave_b_sel,
    output logic      [3:0]   charge_duty_sel
);

    localparam int BIT_W = $clog2(SEGS_PER_COM);

    logic [7:0]                    port_ctrl_r;
    logic [7:0]                    show_ram_select_ctrl_r;
    logic [7:0]                    wave_ctrl_r;
    logic [31:0]                   prdata_r;
    segment_lcd_pkg::seq_state_t   seq_r;
    logic [BIT_W-1:0]              bit_cnt_r;
    logic [1:0]                    com_idx_r;
    logic                          line_alt_r;
    logic                          frame_alt_r;
    logic                          serial_r;
    logic [31:0]                   pin_r;
    logic [3:0]                    back_r;

    logic                          setup_phase;
    logic                          access_phase;
    logic                          running;
    logic                          op_tick;
    logic                          expansion_on;
    logic                          period_end;
    logic                          frame_end;
    logic [1:0]                    com_last;
    segment_lcd_pkg::duty_t        duty;
    logic [31:0]                   drv_mask;
    logic [31:0]                   seg_on;
    logic [3:0]                    com_sel;
    logic [7:0]                    status;

    function automatic logic hit(input logic [31:0] addr, input logic [15:0] idx);
        hit = (addr == 32'({idx, 2'b00}));
    endfunction : hit

    function automatic logic mapped(input logic [31:0] addr);
        mapped = hit(addr, `LCD_PORT_CONTROL_IDX) | hit(addr, `LCD_DISPLAY_CONTROL_IDX)
               | hit(addr, `LCD_WAVE_POWER_CONTROL_IDX) | hit(addr, `LCD_STATUS_IDX);
    endfunction : mapped

    // pin roles from the segment count; expansion leaves every other pin a port
    function automatic logic [31:0] driver_mask(input logic [3:0] cnt, input logic exp);
        logic [31:0] m;
        m = `PORTS_ALL_MASK;
        if (exp)
            m = `PORTS_ALL_MASK;
        else if (cnt[3])
            m = `DRIVERS_ALL_MASK;
        else
        begin
            unique case (cnt[2:1])
                2'h0: m = `PORTS_ALL_MASK;
                2'h1: m = `DRIVERS_TOP8_MASK;
                2'h2: m = `DRIVERS_TOP16_MASK;
                2'h3: m = `DRIVERS_TOP24_MASK;
            endcase
        end
        driver_mask = m;
    endfunction : driver_mask

    assign setup_phase  = psel & ~penable;
    assign access_phase = psel & penable;
    assign pready       = 1'b1;
    // status is read only; a write to it or to a hole is answered with an error
    assign pslverr      = access_phase
                        & (~mapped(paddr) | (pwrite & hit(paddr, `LCD_STATUS_IDX)));
    assign prdata       = prdata_r;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            port_ctrl_r <= `LCD_PORT_CONTROL_RST;
        else if (access_phase && pwrite && hit(paddr, `LCD_PORT_CONTROL_IDX))
            port_ctrl_r <= pwdata[7:0];
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            show_ram_select_ctrl_r <= `LCD_DISPLAY_CONTROL_RST;
        else if (access_phase && pwrite && hit(paddr, `LCD_DISPLAY_CONTROL_IDX))
            show_ram_select_ctrl_r <= pwdata[7:0];
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            wave_ctrl_r <= `LCD_WAVE_POWER_CONTROL_RST;
        else if (access_phase && pwrite && hit(paddr, `LCD_WAVE_POWER_CONTROL_IDX))
            wave_ctrl_r <= pwdata[7:0];
    end

    assign status = {4'h0, running, frame_alt_r, com_idx_r};

    // read data is sampled in the setup cycle and stands through the access cycle
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            prdata_r <= 32'h0000_0000;
        else if (setup_phase && !pwrite)
        begin
            if (hit(paddr, `LCD_PORT_CONTROL_IDX))
                prdata_r <= {24'h00_0000, port_ctrl_r};
            else if (hit(paddr, `LCD_DISPLAY_CONTROL_IDX))
                prdata_r <= {24'h00_0000, show_ram_select_ctrl_r};
            else if (hit(paddr, `LCD_WAVE_POWER_CONTROL_IDX))
                prdata_r <= {24'h00_0000, wave_ctrl_r};
            else if (hit(paddr, `LCD_STATUS_IDX))
                prdata_r <= {24'h00_0000, status};
            else
                prdata_r <= 32'h0000_0000;
        end
    end

    // controller halt; standby also stops the drive
    assign running      = show_ram_select_ctrl_r[`CONTROLLER_ON_BIT] & ~standby;
    // expansion pin select; relied on, a nonzero count is ignored
    assign expansion_on = port_ctrl_r[`EXPANSION_PINS_BIT];
    assign duty         = segment_lcd_pkg::duty_t'(port_ctrl_r[`DUTY_SEL_HI_BIT:`DUTY_SEL_LO_BIT]);
    assign com_last     = duty;
    // driver mapping; expansion keeps 28 ports
    assign drv_mask     = driver_mask(port_ctrl_r[`SEG_COUNT_MSB:`SEG_COUNT_LSB], expansion_on);

    frame_tick_gen u_tick
    (
        .clk      (clk),
        .resetn   (resetn),
        .run      (running),
        .sel      (show_ram_select_ctrl_r[`FRAME_CLK_MSB:`FRAME_CLK_LSB]),
        .sub_tick (sub_clk_tick),
        .op_tick  (op_tick)
    );

    assign period_end = op_tick & (seq_r == segment_lcd_pkg::SEQ_LATCH);
    assign frame_end  = period_end & (com_idx_r == com_last);

    // common period: setup and clock per segment bit, then one latch step
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            seq_r <= segment_lcd_pkg::SEQ_SETUP;
        else if (!running)
            seq_r <= segment_lcd_pkg::SEQ_SETUP;
        else if (op_tick)
        begin
            unique case (seq_r)
                segment_lcd_pkg::SEQ_SETUP: seq_r <= segment_lcd_pkg::SEQ_CLOCK;
                segment_lcd_pkg::SEQ_CLOCK:
                    seq_r <= (bit_cnt_r == BIT_W'(SEGS_PER_COM - 1))
                           ? segment_lcd_pkg::SEQ_LATCH : segment_lcd_pkg::SEQ_SETUP;
                segment_lcd_pkg::SEQ_LATCH: seq_r <= segment_lcd_pkg::SEQ_SETUP;
                default:                    seq_r <= segment_lcd_pkg::SEQ_SETUP;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            bit_cnt_r <= '0;
        else if (!running || period_end)
            bit_cnt_r <= '0;
        else if (op_tick && seq_r == segment_lcd_pkg::SEQ_CLOCK)
            bit_cnt_r <= bit_cnt_r + 1'b1;
    end

    // common index walks 0 .. com_last (the duty field value) each frame
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            com_idx_r <= 2'h0;
        else if (!running || frame_end)
            com_idx_r <= 2'h0;
        else if (period_end)
            com_idx_r <= com_idx_r + 2'h1;
    end

    // A waveform flips polarity each common period
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            line_alt_r <= 1'b0;
        else if (!running)
            line_alt_r <= 1'b0;
        else if (period_end)
            line_alt_r <= ~line_alt_r;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            frame_alt_r <= 1'b0;
        else if (!running)
            frame_alt_r <= 1'b0;
        else if (frame_end)
            frame_alt_r <= ~frame_alt_r;
    end

    // serial data loaded at each setup step; blank when not showing ram
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            serial_r <= 1'b0;
        else if (!running)
            serial_r <= 1'b0;
        else if (seq_r == segment_lcd_pkg::SEQ_SETUP)
            serial_r <= show_ram_select_ctrl_r[`SHOW_RAM_BIT] & ram_bits[{bit_cnt_r, com_idx_r}];
    end

    // internal segment levels for the active common
    generate
        for (genvar k = 0; k < 32; k++)
        begin : g_seg
            assign seg_on[k] = show_ram_select_ctrl_r[`SHOW_RAM_BIT] & ram_bits[{3'h0, 5'(k)} * 4 + com_idx_r];
        end
    endgenerate

    // unused backplanes repeat the used ones when parallel drive is on
    generate
        for (genvar j = 0; j < 4; j++)
        begin : g_com
            assign com_sel[j] = (2'(j) == com_idx_r)
                              || (port_ctrl_r[`COMMON_PARALLEL_BIT] && (2'(j) > com_last)
                                  && (2'(j % (int'(com_last) + 1)) == com_idx_r));
        end
    endgenerate

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            back_r <= 4'h0;
        else
            back_r <= running ? com_sel : 4'h0;
    end

    // top four pins carry expansion signals; others drive segments or stay ports
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            pin_r <= 32'h0000_0000;
        else if (!running)
            pin_r <= 32'h0000_0000;
        else
        begin
            pin_r <= seg_on & drv_mask;
            if (expansion_on)
            begin
                // latch clock on the highest pin
                pin_r[`PIN_LATCH]     <= (seq_r == segment_lcd_pkg::SEQ_LATCH);
                // shift clock on the second-highest pin
                pin_r[`PIN_SHIFT]     <= (seq_r == segment_lcd_pkg::SEQ_CLOCK);
                pin_r[`PIN_SERIAL]    <= serial_r;
                pin_r[`PIN_ALTERNATE] <= frame_alt_r;
            end
        end
    end

    assign frontplane_pin    = pin_r;
    assign frontplane_drv_en = drv_mask | (expansion_on ? `EXPANSION_PIN_MASK : `PORTS_ALL_MASK);
    assign backplane_out     = back_r;
    assign latch_strobe_out  = expansion_on & pin_r[`PIN_LATCH];
    assign shift_strobe_out  = expansion_on & pin_r[`PIN_SHIFT];
    assign serial_seg_out    = expansion_on & pin_r[`PIN_SERIAL];
    assign polarity_flip_out = expansion_on & pin_r[`PIN_ALTERNATE];
    assign expansion_active  = expansion_on & running;

    // waveform select; B waveform follows the frame alternation
    assign wave_b_sel        = wave_ctrl_r[`WAVE_TYPE_BIT];
    assign drive_polarity    = wave_b_sel ? frame_alt_r : line_alt_r;
    // drive power; forced off when halted or in standby
    assign lcd_power_on      = show_ram_select_ctrl_r[`DRIVE_POWER_BIT] & running;
    // step-up regulator runs only when the 5 V supply is chosen
    assign boost_run         = wave_ctrl_r[`BOOST_SUPPLY_BIT];
    assign charge_duty_sel   = wave_ctrl_r[`CHARGE_DUTY_MSB:`CHARGE_DUTY_LSB];

endmodule : segment_lcd_control

// file: hdl/segment_lcd_params.svh
// offsets, field positions, reset values and counts of the segment lcd control block
`ifndef SEGMENT_LCD_PARAMS_SVH
`define SEGMENT_LCD_PARAMS_SVH

// register indices; byte address on apb is four times the index
`define LCD_PORT_CONTROL_IDX       16'hFFC0
`define LCD_DISPLAY_CONTROL_IDX    16'hFFC1
`define LCD_WAVE_POWER_CONTROL_IDX 16'hFFC2
`define LCD_STATUS_IDX             16'hFFC3
`define LCD_ADDR_W                 18
`define LCD_IDX_LSB                2

`define LCD_PORT_CONTROL_RST       8'h00
`define LCD_DISPLAY_CONTROL_RST    8'h80
`define LCD_WAVE_POWER_CONTROL_RST 8'h60

// lcd_port_control fields
`define DUTY_SEL_HI_BIT            7
`define DUTY_SEL_LO_BIT            6
`define COMMON_PARALLEL_BIT        5
`define EXPANSION_PINS_BIT         4
`define SEG_COUNT_MSB              3
`define SEG_COUNT_LSB              0

// lcd_display_control fields
`define DRIVE_POWER_BIT            6
`define CONTROLLER_ON_BIT          5
`define SHOW_RAM_BIT               4
`define FRAME_CLK_MSB              3
`define FRAME_CLK_LSB              0

// lcd_wave_power_control fields
`define WAVE_TYPE_BIT              7
`define BOOST_SUPPLY_BIT           4
`define CHARGE_DUTY_MSB            3
`define CHARGE_DUTY_LSB            0

// pin map of the front plane
`define PORTS_ALL_MASK             32'h0000_0000
`define DRIVERS_TOP8_MASK          32'hFF00_0000
`define DRIVERS_TOP16_MASK         32'hFFFF_0000
`define DRIVERS_TOP24_MASK         32'hFFFF_FF00
`define DRIVERS_ALL_MASK           32'hFFFF_FFFF
`define EXPANSION_PIN_MASK         32'hF000_0000
`define PIN_LATCH                  31
`define PIN_SHIFT                  30
`define PIN_SERIAL                 29
`define PIN_ALTERNATE              28

`define SYS_DIV_W                  8
`define SUB_DIV_W                  2

`endif

// file: hdl/segment_lcd_pkg.sv
// types shared by the segment lcd control block
package segment_lcd_pkg;

    typedef enum logic [1:0]
    {
        DUTY_STATIC  = 2'h0,
        DUTY_HALF    = 2'h1,
        DUTY_THIRD   = 2'h2,
        DUTY_QUARTER = 2'h3
    } duty_t;

    typedef enum logic [2:0]
    {
        SEQ_SETUP = 3'h1,
        SEQ_CLOCK = 3'h2,
        SEQ_LATCH = 3'h4
    } seq_state_t;

endpackage : segment_lcd_pkg

// file: tb/seg_expander_model.sv
// behavioural model of the external serial segment-driver chip
`timescale 1ns/1ns
module seg_expander_model
#(
    parameter int BITS = 4
)
(
    input  wire logic            clk,
    input  wire logic            resetn,
    input  wire logic            latch_strobe_out,
    input  wire logic            shift_strobe_out,
    input  wire logic            serial_seg_out,
    input  wire logic            polarity_flip_out,
    output logic      [BITS-1:0] shown,
    output int                   latches,
    output int                   flips
);
    logic [BITS-1:0] shift_r;
    logic            shift_d_r;
    logic            latch_d_r;
    logic            pol_d_r;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            shift_r   <= '0;
            shown     <= '0;
            latches   <= 0;
            flips     <= 0;
            shift_d_r <= 1'b0;
            latch_d_r <= 1'b0;
            pol_d_r   <= 1'b0;
        end
        else
        begin
            shift_d_r <= shift_strobe_out;
            latch_d_r <= latch_strobe_out;
            pol_d_r   <= polarity_flip_out;
            if (shift_strobe_out && !shift_d_r)
                shift_r <= {serial_seg_out, shift_r[BITS-1:1]};
            if (latch_strobe_out && !latch_d_r)
            begin
                shown   <= shift_r;
                latches <= latches + 1;
            end
            if (polarity_flip_out != pol_d_r)
                flips <= flips + 1;
        end
    end
endmodule : seg_expander_model

// file: tb/segment_lcd_props.sv
// checker: port-level properties of the segment lcd control block
`timescale 1ns/1ns
module segment_lcd_props
(
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        standby,
    input wire logic [31:0] frontplane_drv_en,
    input wire logic [3:0]  backplane_out,
    input wire logic        latch_strobe_out,
    input wire logic        shift_strobe_out,
    input wire logic        serial_seg_out,
    input wire logic        polarity_flip_out,
    input wire logic        expansion_active,
    input wire logic        lcd_power_on
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_power_standby: assert property (standby |-> !lcd_power_on)
        else $error("drive power on during standby");
    a_halt_clears: assert property (standby && $past(standby) |->
        {latch_strobe_out, shift_strobe_out, polarity_flip_out, backplane_out} == 7'h00)
        else $error("outputs active while halted");
    a_latch_shift_apart: assert property (latch_strobe_out |-> !shift_strobe_out)
        else $error("latch and shift high together");
    a_serial_held: assert property (shift_strobe_out && $past(shift_strobe_out) |->
        $stable(serial_seg_out))
        else $error("serial data moved during shift");
    a_exp_pin_roles: assert property (expansion_active |->
        frontplane_drv_en == 32'hF000_0000)
        else $error("expansion pin roles wrong");
    a_alt_at_latch: assert property (expansion_active && $past(expansion_active)
        && $changed(polarity_flip_out) |-> latch_strobe_out || $past(latch_strobe_out))
        else $error("alternation moved away from latch");
    a_unmapped_err: assert property (psel && penable && paddr == 32'h0003_FF10 |-> pslverr)
        else $error("no error for unmapped address");
    a_read_upper_zero: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("read data upper bits set");

    c_latch: cover property (expansion_active && $rose(latch_strobe_out));
    c_power: cover property ($rose(lcd_power_on));
    c_error: cover property (psel && penable && pslverr);
endmodule : segment_lcd_props

bind segment_lcd_control segment_lcd_props u_props
(
    .clk, .resetn, .psel, .penable, .pwrite, .paddr, .prdata, .pslverr, .standby,
    .frontplane_drv_en, .backplane_out, .latch_strobe_out, .shift_strobe_out,
    .serial_seg_out, .polarity_flip_out, .expansion_active, .lcd_power_on
);

// file: tb/tb.sv
// self-checking bench for the segment lcd control block
`timescale 1ns/1ns
module tb;
    localparam logic [31:0] A_PORT = 32'h0003_FF00;
    localparam logic [31:0] A_SHOW_RAM_SELECT = 32'h0003_FF04;
    localparam logic [31:0] A_WAVE = 32'h0003_FF08;
    localparam logic [31:0] A_NONE = 32'h0003_FF10;
    logic         clk, resetn, psel, penable, pwrite, pready, pslverr;
    logic         sub_clk_tick, standby, drive_polarity, expansion_active;
    logic         latch_strobe_out, shift_strobe_out, serial_seg_out, polarity_flip_out;
    logic         lcd_power_on, boost_run, wave_b_sel, e;
    logic [31:0]  paddr, pwdata, prdata, frontplane_pin, frontplane_drv_en, q;
    logic [255:0] ram_bits;
    logic [3:0]   backplane_out, charge_duty_sel, shown;
    int           latches, flips, n_mismatch, samples_checked, base_f, i;

    segment_lcd_control #(.SEGS_PER_COM(4)) DUT
    (
        .clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .sub_clk_tick, .standby, .ram_bits, .frontplane_pin,
        .frontplane_drv_en, .backplane_out, .drive_polarity, .latch_strobe_out,
        .shift_strobe_out, .serial_seg_out, .polarity_flip_out, .expansion_active,
        .lcd_power_on, .boost_run, .wave_b_sel, .charge_duty_sel
    );
    seg_expander_model #(.BITS(4)) far_end
    (
        .clk, .resetn, .latch_strobe_out, .shift_strobe_out, .serial_seg_out,
        .polarity_flip_out, .shown, .latches, .flips
    );

    initial clk = 1'b0;
    always #5 clk = ~clk;
    always @(posedge clk) sub_clk_tick <= ~sub_clk_tick;

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge clk);
            if (pready === 1'b1)
                break;
        end
        if (n == 50)
        begin
            n_mismatch++;
            tally_and_finish();
        end
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_latch(input int k);
        int n;
        int b;
        b = latches;
        for (n = 0; n < 2000 && latches < b + k; n++)
            @(posedge clk);
        if (n == 2000)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask : wait_latch

    // halt, change pin setup, run again at clk/2 with power and ram shown
    task automatic run_mode(input logic [31:0] p);
        apb(1'b1, A_SHOW_RAM_SELECT, 32'h0000_00D8);
        apb(1'b1, A_PORT, p);
        apb(1'b1, A_SHOW_RAM_SELECT, 32'h0000_00F8);
        #1;
    endtask : run_mode

    function automatic logic [31:0] pin_mask(input logic [3:0] c);
        if (c[3])
            return 32'hFFFF_FFFF;
        case (c[2:1])
            2'h0: return 32'h0000_0000;
            2'h1: return 32'hFF00_0000;
            2'h2: return 32'hFFFF_0000;
            default: return 32'hFFFF_FF00;
        endcase
    endfunction : pin_mask

    initial
    begin
        {resetn, psel, penable, pwrite, sub_clk_tick, standby} = 6'h00;
        paddr = 32'h0;
        pwdata = 32'h0;
        ram_bits = 256'hF0FF;
        n_mismatch = 0;
        samples_checked = 0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        apb(1'b0, A_PORT, 32'h0);
        chk("port_rst", q, 32'h0000_0000);
        apb(1'b0, A_SHOW_RAM_SELECT, 32'h0);
        chk("show_ram_select_rst", q, 32'h0000_0080);
        apb(1'b0, A_WAVE, 32'h0);
        chk("wave_rst", q, 32'h0000_0060);
        apb(1'b1, A_NONE, 32'h0000_00FF);
        chk("wr_err", 32'(e), 32'h1);
        apb(1'b1, 32'h0003_FF0C, 32'h0000_00FF);
        chk("ro_err", 32'(e), 32'h1);
        apb(1'b0, A_NONE, 32'h0);
        chk("rd_none", q, 32'h0000_0000);
        $display("test registers done");
        apb(1'b1, A_WAVE, 32'h0000_0091);
        apb(1'b0, A_WAVE, 32'h0);
        chk("wave_rw", q, 32'h0000_0091);
        chk("boost", 32'(boost_run), 32'h1);
        chk("wave_b", 32'({wave_b_sel, charge_duty_sel}), 32'h11);
        // external supply: plain supply, drive power off
        apb(1'b1, A_WAVE, 32'h0000_0000);
        apb(1'b1, A_SHOW_RAM_SELECT, 32'h0000_00B8);
        #1;
        chk("ext_sup", 32'({boost_run, wave_b_sel, lcd_power_on}), 32'h0);
        for (i = 0; i < 16; i++)
        begin
            apb(1'b1, A_PORT, 32'(i));
            #1;
            chk("drv_en", frontplane_drv_en, pin_mask(i[3:0]));
            chk("exp_off", 32'(expansion_active), 32'h0);
        end
        @(posedge clk);
        #1;
        chk("seg_pins", frontplane_pin, 32'h0000_000B);
        $display("test pin map done");
        // expansion only ever with a zero count
        run_mode(32'h0000_00D0);
        chk("exp_pins", frontplane_drv_en, 32'hF000_0000);
        chk("pwr_on", 32'({expansion_active, lcd_power_on}), 32'h3);
        wait_latch(3);
        chk("serial", 32'(shown), 32'h0000_000B);
        chk("pol_a", 32'(drive_polarity), 32'h1);
        apb(1'b1, A_SHOW_RAM_SELECT, 32'h0000_00E8);
        wait_latch(2);
        chk("blank", 32'(shown), 32'h0);
        $display("test expansion done");
        for (i = 0; i < 4; i++)
        begin
            apb(1'b1, A_SHOW_RAM_SELECT, 32'h0000_00D8);
            #1;
            chk("pwr_halt", 32'(lcd_power_on), 32'h0);
            apb(1'b0, A_PORT, 32'h0);
            chk("kept", q, (i == 0) ? 32'h0000_00D0 : 32'(8'h10 | ((i - 1) << 6)));
            run_mode(32'h0000_0010 | 32'(i << 6));
            base_f = flips;
            wait_latch(12);
            repeat (4) @(posedge clk);
            chk("frames", 32'(flips - base_f), 32'(12 / (i + 1)));
        end
        $display("test duty done");
        run_mode(32'h0000_0070);
        repeat (40) @(posedge clk);
        chk("bp_par", 32'(backplane_out == 4'h5 || backplane_out == 4'hA), 32'h1);
        run_mode(32'h0000_0050);
        repeat (40) @(posedge clk);
        chk("bp_solo", 32'(backplane_out[3:2]), 32'h0);
        $display("test commons done");
        standby <= 1'b1;
        repeat (30) @(posedge clk);
        chk("pwr_sby", 32'(lcd_power_on), 32'h0);
        chk("sby_pins", 32'({latch_strobe_out, shift_strobe_out}), 32'h0);
        standby <= 1'b0;
        wait_latch(2);
        chk("resume", 32'(lcd_power_on), 32'h1);
        apb(1'b1, A_SHOW_RAM_SELECT, 32'h0000_00F2);
        wait_latch(2);
        base_f = int'($time);
        wait_latch(1);
        chk("sub_div4", 32'(int'($time) - base_f), 32'h0000_02D0);
        $display("test standby done");
        tally_and_finish();
    end

    initial
    begin
        repeat (50000) @(posedge clk);
        n_mismatch++;
        tally_and_finish();
    end
endmodule : tb
